// >>> rfc_card.sv
// Card-side model: a demodulated bit stream offered to the receiver
`timescale 1ns/10ps
module rfc_card (
   // Clock and handshake
   input wire logic clk_i,
   input wire logic rx_ready_i,
   // Beats towards the receiver
   output rfc_pkg::rfc_rx_beat_t rx_o
);
   import rfc_pkg::*;

   // Nothing offered at start
   initial rx_o = '0;

   // Sends n bits, first bit first, then the end marker; each beat held
   // until the receiver shows ready at the taking edge
   task automatic send(input logic [15:0] bits, input int n);
      for (int i = 0; i <= n; i++) begin
         rx_o <= '{valid: (i < n), data: (i < n) ? bits[i] : 1'b0,
                   stream_end: (i == n)};
         do @(negedge clk_i); while (rx_ready_i !== 1'b1);
         @(posedge clk_i);
      end
      // Released: data shows the inverse of the last bit, never stale
      rx_o <= '{valid: 1'b0, data: ~bits[n - 1], stream_end: 1'b0};
   endtask
endmodule // rfc_card

// >>> rfc_ctrl.sv
// Receive mode control, receive buffer and antenna driver control
//
// What this block does
// - With ignore_short_frames set, a stream of under four bits is dropped and the receiver stays on.
// - With multi_frame_receive clear, the receiver turns off after one frame.
// - With multi_frame_receive set, frames keep being received one after another.
// - In multi-frame mode reception ends only on an idle command or on clearing the multi bit.
// - In multi-frame mode each stream not dropped as short is followed by a FIFO byte copying the error register.
// - The two-bit rx_framing_select picks type A, active, 212/424 passive or type B framing.
// - An enabled driver is inverted when its invert-when-on bit is set (bit 7 driver 2, bit 6 driver 1).
// - A disabled driver is inverted when its invert-when-off bit is set (bit 5 driver 2, bit 4 driver 1).
// - With drv2_carrier_only set, driver 2 gives the plain carrier and ignores transmit data.
// - With drv2_carrier_only (bit 3) clear, driver 2's carrier is modulated by transmit data.
// - With field_check_block (bit 2) written 1, no driver enable is set while a field is seen.
// - That blocking acts only for drivers whose auto RF-on bit is set.
// - With drv2_enable (bit 1) set, driver 2 gives the carrier modulated by transmit data.
// - With drv1_enable (bit 0) set, driver 1 gives the carrier modulated by transmit data.
// - A driver with auto RF-on set is enabled by hardware a delay after the outside field drops.
`timescale 1ns/10ps

// Receive byte buffer built from flip-flops
module rfc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   output logic [$clog2(DEPTH):0] level_o
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   wire push = in_valid_i & in_ready_o;
   wire pop = out_valid_o & out_ready_i;

   // Depth must be a power of two of at least two for pointer wrap
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("rfc_fifo: DEPTH must be a power of two, at least 2");
   end

   // Flags and head word
   assign in_ready_o = (count != FULL);
   assign out_valid_o = (count != '0);
   assign out_data_o = mem[rd_ptr];
   assign level_o = count;

   // Pointers and fill count
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= wr_ptr + AW'(push);
         rd_ptr <= rd_ptr + AW'(pop);
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // Storage write
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end
endmodule // rfc_fifo

// Top of the receive mode and antenna driver control
module rfc_ctrl #(
   parameter int T_ADT_NS = rfc_pkg::T_ADT_NS_DEF
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire rfc_pkg::rfc_bus_req_t bus_i,
   output logic [rfc_pkg::DATA_W-1:0] rdata_o,
   // Demodulated receive stream
   input wire rfc_pkg::rfc_rx_beat_t rx_i,
   output logic rx_ready_o,
   output logic rx_active_o,
   output rfc_pkg::rfc_framing_t rx_framing_o,
   // Transmitter
   input wire logic carrier_i,
   input wire logic tx_data_i,
   input wire logic field_detect_i,
   output logic antenna_driver_1_o,
   output logic antenna_driver_2_o
);
   import rfc_pkg::*;

   localparam int ADT_CYC_I = (T_ADT_NS + CLK_NS - 1) / CLK_NS;
   localparam int ADT_CYC = (ADT_CYC_I < 1) ? 1 : ADT_CYC_I;
   localparam int ADT_W = $clog2(ADT_CYC + 1);
   // Last count value; the fall cycle itself is count zero
   localparam logic [ADT_W-1:0] ADT_LAST = ADT_W'(ADT_CYC - 1);

   if (ADT_CYC > 4096) begin : g_bad_adt
      $error("rfc_ctrl: T_ADT_NS gives too long a count");
   end

   typedef enum logic [4:0] {
      ST_OFF = 5'h01,
      ST_RUN = 5'h02,
      ST_PUSH = 5'h04,
      ST_LAST = 5'h08,
      ST_ERR = 5'h10
   } rfc_state_t;

   rfc_state_t st, next_st;
   logic [7:0] rx_mode;
   rfc_tx_ctrl_t txc;
   logic [7:0] tx_auto;
   logic [CMD_W-1:0] cmd;
   logic [7:0] err;
   logic [7:0] shreg;
   logic [2:0] nbits;
   logic [2:0] tot;
   logic fld_s1, fld_s2, fld_s3, fld_q;
   logic [ADT_W-1:0] adt_cnt;
   logic fifo_in_ready, fifo_out_valid;
   logic [7:0] fifo_out_data;
   logic [$clog2(FIFO_DEPTH):0] fifo_level;
   logic [7:0] fifo_wdata;

   // Register port decode
   wire wr_rxm = bus_i.we & (bus_i.addr == RX_MODE_ADDR);
   wire wr_txc = bus_i.we & (bus_i.addr == TX_CTRL_ADDR);
   wire wr_txa = bus_i.we & (bus_i.addr == TX_AUTO_ADDR);
   wire wr_cmd = bus_i.we & (bus_i.addr == CMD_ADDR);
   wire wr_err = bus_i.we & (bus_i.addr == ERR_ADDR);
   wire rd_fifo = bus_i.re & (bus_i.addr == FIFO_DATA_ADDR);
   wire [3:0] wcmd = bus_i.wdata[CMD_W-1:0];
   wire rfc_tx_ctrl_t wtx = rfc_tx_ctrl_t'(bus_i.wdata);

   // Receive mode fields
   wire ignore_short_frames = rx_mode[RXM_IGNORE_BIT];
   wire multi_frame_receive = rx_mode[RXM_MULTI_BIT];
   assign rx_framing_o = rfc_framing_t'(rx_mode[RXM_FRAME_LSB +: 2]);

   // Command and stream events
   wire start_cmd = wr_cmd & ((wcmd == CMD_RECEIVE) |
                              (wcmd == CMD_TRANSCEIVE));
   wire stop_cmd = (wr_cmd & (wcmd == CMD_IDLE)) |
                   (wr_rxm & multi_frame_receive &
                    ~bus_i.wdata[RXM_MULTI_BIT]);
   assign rx_ready_o = (st == ST_RUN);
   assign rx_active_o = (st != ST_OFF);
   wire end_take = rx_ready_o & rx_i.stream_end;
   wire bit_take = rx_ready_o & rx_i.valid & ~rx_i.stream_end;
   wire tot_short = (tot < MIN_BITS);
   wire drop_short = end_take & tot_short & ignore_short_frames;
   wire set_short = end_take & tot_short & ~ignore_short_frames;
   wire fifo_push = (st == ST_PUSH) | (st == ST_LAST) | (st == ST_ERR);
   wire push_done = fifo_push & fifo_in_ready;
   wire clr_cnt = start_cmd | drop_short |
                  (end_take & (nbits == '0)) |
                  ((st == ST_LAST) & fifo_in_ready);
   wire [3:0] pad = 4'(4'h8 - {1'b0, nbits});

   // FIFO write word: full byte, right-aligned partial byte, error copy
   // error byte copy
   assign fifo_wdata = (st == ST_ERR) ? err :
                       (st == ST_LAST) ? (shreg >> pad) : shreg;

   // Receive sequence
   always_comb begin
      next_st = st;
      unique case (st)
         ST_OFF: begin
            if (start_cmd) next_st = ST_RUN;
         end
         ST_RUN: begin
            if (drop_short) begin
               next_st = ST_RUN;
            end else if (end_take && nbits != '0) begin
               next_st = ST_LAST;
            end else if (end_take) begin
               next_st = multi_frame_receive ? ST_ERR : ST_OFF;
            end else if (bit_take && nbits == LAST_BIT_IDX) begin
               next_st = ST_PUSH;
            end
         end
         ST_PUSH: begin
            if (fifo_in_ready) next_st = ST_RUN;
         end
         ST_LAST: begin
            if (fifo_in_ready) begin
               next_st = multi_frame_receive ? ST_ERR : ST_OFF;
            end
         end
         ST_ERR: begin
            if (fifo_in_ready) next_st = ST_RUN;
         end
         default: next_st = ST_OFF;
      endcase
      // idle command or multi bit cleared
      if (stop_cmd) next_st = ST_OFF;
   end

   // State register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) st <= ST_OFF;
      else st <= next_st;
   end

   // Bit assembly, least significant bit first
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shreg <= 8'h00;
         nbits <= '0;
         tot <= '0;
      end else if (clr_cnt) begin
         nbits <= '0;
         tot <= '0;
      end else if (bit_take) begin
         shreg <= {rx_i.data, shreg[7:1]};
         nbits <= nbits + 3'h1;
         tot <= tot_short ? tot + 3'h1 : tot;
      end
   end

   // Command register returns to idle when a single frame ends
   wire self_idle = (st != ST_OFF) & (next_st == ST_OFF);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) cmd <= CMD_IDLE;
      else if (wr_cmd) cmd <= wcmd;
      else if (self_idle) cmd <= CMD_IDLE;
   end

   // Error flags: write 1 to clear, a new event wins
   wire [7:0] err_set = 8'(set_short) << ERR_SHORT_BIT;
   wire [7:0] err_clr = wr_err ? bus_i.wdata : 8'h00;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) err <= ERR_RST;
      else err <= (err & ~err_clr) | err_set;
   end

   // Mode and auto-on registers
   // framing select stored
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_mode <= RX_MODE_RST;
         tx_auto <= TX_AUTO_RST;
      end else begin
         if (wr_rxm) rx_mode <= bus_i.wdata & RX_MODE_MASK;
         if (wr_txa) begin
            tx_auto <= bus_i.wdata &
                       ((8'h01 << TXA_DRV2_AUTO_BIT) |
                        (8'h01 << TXA_DRV1_AUTO_BIT));
         end
      end
   end

   // Outside field detector, three stages, change taken on agreement
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fld_s1 <= 1'b0;
         fld_s2 <= 1'b0;
         fld_s3 <= 1'b0;
         fld_q <= 1'b0;
      end else begin
         fld_s1 <= field_detect_i;
         fld_s2 <= fld_s1;
         fld_s3 <= fld_s2;
         if (fld_s2 == fld_s3) fld_q <= fld_s3;
      end
   end

   // Delay after the outside field drops; counting starts as the filtered
   // level falls, so the enable lands ADT_CYC edges after that fall
   wire fld_fall = ~fld_s3 & ~fld_s2 & fld_q;
   logic adt_run;
   wire adt_fire = adt_run & (adt_cnt == ADT_LAST);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) adt_cnt <= '0;
      else if (fld_fall || !adt_run) adt_cnt <= '0;
      else adt_cnt <= adt_cnt + ADT_W'(1);
   end
   // Timer runs from the fall until it fires or the field comes back
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) adt_run <= 1'b0;
      else adt_run <= fld_fall | (adt_run & ~fld_q & ~adt_fire);
   end

   // Driver enables
   wire auto1 = tx_auto[TXA_DRV1_AUTO_BIT];
   wire auto2 = tx_auto[TXA_DRV2_AUTO_BIT];
   // hardware sets the enable after the delay
   wire auto_set1 = adt_fire & auto1;
   wire auto_set2 = adt_fire & auto2;
   // refuse enables while a field is present
   wire blk1 = wtx.chk & auto1 & fld_q;
   wire blk2 = wtx.chk & auto2 & fld_q;
   wire next_en1 = auto_set1 | (wr_txc ? (wtx.en1 & ~blk1) : txc.en1);
   wire next_en2 = auto_set2 | (wr_txc ? (wtx.en2 & ~blk2) : txc.en2);
   rfc_tx_ctrl_t next_txc;
   always_comb begin
      next_txc = wr_txc ? wtx : txc;
      next_txc.chk = 1'b0;
      next_txc.en1 = next_en1;
      next_txc.en2 = next_en2;
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) txc <= rfc_tx_ctrl_t'(TX_CTRL_RST);
      else txc <= next_txc;
   end

   // Driver sources: modulated carrier, or plain carrier on driver 2
   // carrier-only select on driver 2
   wire src1 = carrier_i & tx_data_i;
   wire src2 = carrier_i & (txc.cw2 | tx_data_i);
   wire next_drv1 = rfc_drive(src1, txc.en1, txc.inv1_on, txc.inv1_off);
   wire next_drv2 = rfc_drive(src2, txc.en2, txc.inv2_on, txc.inv2_off);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         antenna_driver_1_o <= 1'b0;
         antenna_driver_2_o <= 1'b0;
      end else begin
         antenna_driver_1_o <= next_drv1;
         antenna_driver_2_o <= next_drv2;
      end
   end

   // Receive buffer
   rfc_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(fifo_push),
      .in_ready_o(fifo_in_ready),
      .in_data_i(fifo_wdata),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(rd_fifo),
      .out_data_o(fifo_out_data),
      .level_o(fifo_level)
   );

   // Read mux, answered one cycle after the strobe
   wire [7:0] rd_mux =
      (bus_i.addr == RX_MODE_ADDR) ? rx_mode :
      (bus_i.addr == TX_CTRL_ADDR) ? 8'(txc) :
      (bus_i.addr == TX_AUTO_ADDR) ? tx_auto :
      (bus_i.addr == CMD_ADDR) ? 8'(cmd) :
      (bus_i.addr == ERR_ADDR) ? err :
      (bus_i.addr == FIFO_DATA_ADDR) ?
         (fifo_out_valid ? fifo_out_data : 8'h00) :
      (bus_i.addr == FIFO_LEVEL_ADDR) ? 8'(fifo_level) : 8'h00;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) rdata_o <= 8'h00;
      else if (bus_i.re) rdata_o <= rd_mux;
      else rdata_o <= 8'h00;
   end

   // Checks
   sequence s_end_short;
      (st == ST_RUN) && rx_i.stream_end && tot_short;
   endsequence
   sequence s_end_whole;
      (st == ST_RUN) && rx_i.stream_end && !tot_short && nbits == '0;
   endsequence

   property p_short_drop;
      @(posedge clk_i) disable iff (!rst_n_i)
      s_end_short ##0 (ignore_short_frames && !stop_cmd)
         |=> (st == ST_RUN) && !fifo_push ##1 !fifo_push;
   endproperty
   a_short_drop: assert property (p_short_drop)
      else $error("short stream not dropped");

   property p_single_off;
      @(posedge clk_i) disable iff (!rst_n_i)
      s_end_whole ##0 !multi_frame_receive |=> (st == ST_OFF)
         && (cmd == CMD_IDLE);
   endproperty
   a_single_off: assert property (p_single_off)
      else $error("receiver still on after one frame");

   property p_multi_on;
      @(posedge clk_i) disable iff (!rst_n_i)
      s_end_whole ##0 (multi_frame_receive && !stop_cmd)
         |=> (st == ST_ERR) ##[1:40] (st == ST_RUN);
   endproperty
   a_multi_on: assert property (p_multi_on)
      else $error("multi-frame receive did not continue");

   property p_idle_stop;
      @(posedge clk_i) disable iff (!rst_n_i)
      stop_cmd |=> (st == ST_OFF) && !rx_active_o;
   endproperty
   a_idle_stop: assert property (p_idle_stop)
      else $error("idle command did not stop reception");

   property p_err_copy;
      @(posedge clk_i) disable iff (!rst_n_i)
      (st == ST_ERR) && fifo_in_ready |-> fifo_wdata == err;
   endproperty
   a_err_copy: assert property (p_err_copy)
      else $error("error byte differs from error register");

   property p_framing;
      @(posedge clk_i) disable iff (!rst_n_i)
      wr_rxm |=> rx_framing_o == $past(bus_i.wdata[1:0]);
   endproperty
   a_framing: assert property (p_framing)
      else $error("framing select not taken");

   property p_inv_on;
      @(posedge clk_i) disable iff (!rst_n_i)
      txc.en1 && txc.inv1_on |=> antenna_driver_1_o != $past(src1);
   endproperty
   a_inv_on: assert property (p_inv_on)
      else $error("driver 1 not inverted while on");

   property p_inv_off;
      @(posedge clk_i) disable iff (!rst_n_i)
      !txc.en2 |=> antenna_driver_2_o == $past(txc.inv2_off);
   endproperty
   a_inv_off: assert property (p_inv_off)
      else $error("driver 2 wrong while off");

   property p_cw;
      @(posedge clk_i) disable iff (!rst_n_i)
      txc.en2 && txc.cw2 && carrier_i |=>
         antenna_driver_2_o == !$past(txc.inv2_on);
   endproperty
   a_cw: assert property (p_cw)
      else $error("carrier-only output modulated");

   property p_block;
      @(posedge clk_i) disable iff (!rst_n_i)
      wr_txc && wtx.chk && wtx.en1 && auto1 && fld_q && !auto_set1
         |=> !txc.en1;
   endproperty
   a_block: assert property (p_block)
      else $error("enable set during outside field");

   property p_auto_on;
      @(posedge clk_i) disable iff (!rst_n_i)
      adt_fire && auto2 |=> txc.en2;
   endproperty
   a_auto_on: assert property (p_auto_on)
      else $error("auto RF-on did not enable driver 2");
endmodule // rfc_ctrl

// >>> rfc_pkg.sv
// Shared constants, types and helpers of the RF receive/driver control block
package rfc_pkg;
   // Bus widths
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   // Register map
   localparam logic [15:0] RX_MODE_ADDR = 16'h6303;
   localparam logic [15:0] TX_CTRL_ADDR = 16'h6304;
   localparam logic [15:0] TX_AUTO_ADDR = 16'h6305;
   localparam logic [15:0] CMD_ADDR = 16'h6310;
   localparam logic [15:0] ERR_ADDR = 16'h6311;
   localparam logic [15:0] FIFO_DATA_ADDR = 16'h6312;
   localparam logic [15:0] FIFO_LEVEL_ADDR = 16'h6313;
   // Receive mode fields
   localparam int RXM_IGNORE_BIT = 3;
   localparam int RXM_MULTI_BIT = 2;
   localparam int RXM_FRAME_LSB = 0;
   localparam logic [7:0] RX_MODE_RST = 8'h00;
   localparam logic [7:0] RX_MODE_MASK = 8'h0F;
   // Driver control and auto-on fields
   localparam logic [7:0] TX_CTRL_RST = 8'h80;
   localparam logic [7:0] TX_AUTO_RST = 8'h00;
   localparam int TXA_DRV2_AUTO_BIT = 1;
   localparam int TXA_DRV1_AUTO_BIT = 0;
   // Command codes
   localparam int CMD_W = 4;
   localparam logic [3:0] CMD_IDLE = 4'h0;
   localparam logic [3:0] CMD_RECEIVE = 4'h8;
   localparam logic [3:0] CMD_TRANSCEIVE = 4'hC;
   // Error flags
   localparam int ERR_SHORT_BIT = 0;
   localparam logic [7:0] ERR_RST = 8'h00;
   // Receive stream figures
   localparam logic [2:0] MIN_BITS = 3'h4;
   localparam logic [2:0] LAST_BIT_IDX = 3'h7;
   localparam int FIFO_DEPTH = 16;
   // Timing
   localparam int CLK_NS = 20;
   localparam int T_ADT_NS_DEF = 1000;

   // Expected receive framing
   typedef enum logic [1:0] {
      FRM_TYPE_A = 2'h0,
      FRM_ACTIVE = 2'h1,
      FRM_PASSIVE_HI = 2'h2,
      FRM_TYPE_B = 2'h3
   } rfc_framing_t;

   // Register bus request
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic we;
      logic re;
   } rfc_bus_req_t;

   // Driver control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic inv2_on;
      logic inv1_on;
      logic inv2_off;
      logic inv1_off;
      logic cw2;
      logic chk;
      logic en2;
      logic en1;
   } rfc_tx_ctrl_t;

   // Demodulated receive stream beat
   typedef struct packed {
      logic valid;
      logic data;
      logic stream_end;
   } rfc_rx_beat_t;

   // Driver pin level from its source, enable and invert bits
   function automatic logic rfc_drive(input logic src, input logic en,
                                      input logic inv_on,
                                      input logic inv_off);
      rfc_drive = (en & src) ^ (en ? inv_on : inv_off);
   endfunction
endpackage

// >>> tb_top.sv
// Self-checking testbench of the receive mode and driver control block
`timescale 1ns/10ps
module tb_top;
   import rfc_pkg::*;
   localparam int ADT_NS = 100;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   rfc_bus_req_t bus = '0;
   rfc_rx_beat_t rx;
   logic [7:0] rdata;
   logic rx_ready;
   logic rx_active;
   rfc_framing_t framing;
   logic carrier = 1'b0;
   logic tx_data = 1'b0;
   logic field = 1'b0;
   logic drv1;
   logic drv2;
   logic re_d = 1'b0;
   int bad_count = 0;
   int cmp_count = 0;
   logic [7:0] exp_q[$];
   logic [7:0] v;
   logic e1;
   logic e2;

   // Clock at 50 MHz
   always #10 clk_i = ~clk_i;

   // Design and card model
   rfc_ctrl #(.T_ADT_NS(ADT_NS)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .bus_i(bus), .rdata_o(rdata), .rx_i(rx), .rx_ready_o(rx_ready),
      .rx_active_o(rx_active), .rx_framing_o(framing),
      .carrier_i(carrier), .tx_data_i(tx_data), .field_detect_i(field),
      .antenna_driver_1_o(drv1), .antenna_driver_2_o(drv2));
   rfc_card i_card (.clk_i(clk_i), .rx_ready_i(rx_ready), .rx_o(rx));

   // One counted compare
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Register write, one idle cycle after it
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      @(posedge clk_i);
      bus <= '0;
      @(posedge clk_i);
   endtask

   // Register read; the expected value is noted for the monitor
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
      exp_q.push_back(exp);
      @(posedge clk_i);
      bus <= '0;
      @(posedge clk_i);
   endtask

   // Receiver state seen mid-cycle
   task automatic active(input logic exp);
      @(negedge clk_i);
      check({7'h00, rx_active}, {7'h00, exp});
      @(posedge clk_i);
   endtask

   task automatic done(input string s);
      $display("Test %s finished", s);
   endtask

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Read data stand one cycle after the strobe: compare with oldest note
   always @(posedge clk_i) re_d <= bus.re;
   always @(negedge clk_i) begin
      if (re_d === 1'b1 && exp_q.size() > 0)
         check(rdata, exp_q.pop_front());
   end

   // Watchdog well beyond the expected run length
   initial begin
      #(5000 * 20);
      bad_count++;
      end_of_test();
   end

   // Main sequence
   initial begin
      void'($urandom(8));
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      rd(TX_CTRL_ADDR, TX_CTRL_RST);
      rd(RX_MODE_ADDR, RX_MODE_RST);
      wr(16'h6300, 8'hFF);
      rd(16'h6300, 8'h00);
      done("reset");
      // Every framing code, upper bits refused
      for (int f = 0; f < 4; f++) begin
         wr(RX_MODE_ADDR, 8'hF0 | 8'(f));
         rd(RX_MODE_ADDR, 8'(f));
         @(negedge clk_i);
         check({6'h00, framing}, 8'(f));
         @(posedge clk_i);
      end
      done("framing");
      // Random driver settings against carrier and transmit data
      for (int k = 0; k < 40; k++) begin
         v = 8'($urandom());
         wr(TX_CTRL_ADDR, v);
         rd(TX_CTRL_ADDR, v & 8'hFB);
         carrier <= 1'($urandom());
         tx_data <= 1'($urandom());
         @(posedge clk_i);
         @(negedge clk_i);
         e1 = carrier & tx_data;
         e2 = carrier & (v[3] | tx_data);
         e1 = v[0] ? e1 ^ v[6] : v[4];
         e2 = v[1] ? e2 ^ v[7] : v[5];
         check({7'h00, drv1}, {7'h00, e1});
         check({7'h00, drv2}, {7'h00, e2});
         @(posedge clk_i);
      end
      done("drivers");
      // Single frame turns the receiver off
      wr(RX_MODE_ADDR, 8'h00);
      wr(CMD_ADDR, {4'h0, CMD_RECEIVE});
      i_card.send(16'h00A5, 8);
      active(1'b0);
      rd(FIFO_LEVEL_ADDR, 8'h01);
      rd(FIFO_DATA_ADDR, 8'hA5);
      rd(CMD_ADDR, {4'h0, CMD_IDLE});
      done("single");
      // Short stream ignored, receiver stays on until idle
      wr(RX_MODE_ADDR, 8'h08);
      wr(CMD_ADDR, {4'h0, CMD_RECEIVE});
      i_card.send(16'h0003, 2);
      repeat (3) @(posedge clk_i);
      active(1'b1);
      rd(FIFO_LEVEL_ADDR, 8'h00);
      rd(ERR_ADDR, 8'h00);
      wr(CMD_ADDR, {4'h0, CMD_IDLE});
      active(1'b0);
      done("short");
      // Multi-frame: error copy after each stream, stop on clearing
      wr(RX_MODE_ADDR, 8'h04);
      wr(CMD_ADDR, {4'h0, CMD_TRANSCEIVE});
      i_card.send(16'h003C, 8);
      repeat (3) @(posedge clk_i);
      active(1'b1);
      i_card.send(16'h0005, 3);
      repeat (3) @(posedge clk_i);
      active(1'b1);
      rd(FIFO_LEVEL_ADDR, 8'h04);
      rd(FIFO_DATA_ADDR, 8'h3C);
      rd(FIFO_DATA_ADDR, 8'h00);
      rd(FIFO_DATA_ADDR, 8'h05);
      rd(FIFO_DATA_ADDR, 8'h01);
      wr(ERR_ADDR, 8'h01);
      rd(ERR_ADDR, 8'h00);
      wr(RX_MODE_ADDR, 8'h00);
      active(1'b0);
      done("multi");
      // Field check blocking and automatic switch-on after field drop
      wr(TX_AUTO_ADDR, 8'h00);
      field <= 1'b1;
      repeat (6) @(posedge clk_i);
      wr(TX_CTRL_ADDR, 8'h07);
      rd(TX_CTRL_ADDR, 8'h03);
      wr(TX_CTRL_ADDR, 8'h00);
      wr(TX_AUTO_ADDR, 8'h03);
      wr(TX_CTRL_ADDR, 8'h07);
      rd(TX_CTRL_ADDR, 8'h00);
      rd(TX_AUTO_ADDR, 8'h03);
      field <= 1'b0;
      // Enable due five edges after the filtered fall: still off here
      repeat (6) @(posedge clk_i);
      rd(TX_CTRL_ADDR, 8'h00);
      repeat (20) @(posedge clk_i);
      rd(TX_CTRL_ADDR, 8'h03);
      done("field");
      repeat (2) @(posedge clk_i);
      end_of_test();
   end
endmodule // tb_top
